// >>> hw/ptsio_top.sv
// discrete i/o logic of a single-axis pulse-train servo driver
// assumes an ahb-lite master on hclk; pins are asynchronous;
// home_found, motor_ready, fb_step and fb_dir come from hclk logic
//
// Contract
// - decode quadrature, pulse plus sign or cw/ccw per the configured form.
// - search home while home_request and servo_state_out are both on, and abort once either drops.
// - energize the motor while the enable input is on and no alarm is latched, else not.
// - raise homing_done once the home search has finished.
// - raise in_position while the deviation count lies within tolerance.
// - hold fault_n high when healthy and drop it on any alarm.
// - raise servo_state_out while the motor is really servo-on.
// - hold a 4-bit unit number for a chain of up to 16; it gates no register access.
// - raise an alarm on deviation, speed overrun or frequency overrun.
`timescale 1ns/1ps
`include "ptsio_map.svh"
module ptsio_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cmd_pulse_in_a,
  input wire logic cmd_pulse_in_b,
  input wire logic cmd_direction_in_a,
  input wire logic cmd_direction_in_b,
  input wire logic home_request,
  input wire logic motor_enable_in_alt,
  input wire logic alarm_reset_in,
  input wire logic ext_fault_in,
  input wire logic home_found,
  input wire logic motor_ready,
  input wire logic fb_step,
  input wire logic fb_dir,
  output logic homing_done,
  output logic homing_active,
  output logic in_position,
  output logic fault_n,
  output logic servo_state_out,
  output logic motor_energize
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: s1 feeds only s2
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] pins;
  assign pins = {ext_fault_in, alarm_reset_in, motor_enable_in_alt,
                 home_request, cmd_direction_in_b, cmd_direction_in_a,
                 cmd_pulse_in_b, cmd_pulse_in_a};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  logic home_s, en_s, rst_s, ext_s;
  assign home_s = s2_r[4];
  assign en_s = s2_r[5];
  assign rst_s = s2_r[6];
  assign ext_s = s2_r[7];

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [15:0] tol_r, tol_nxt, devlim_r, devlim_nxt, spdlim_r, spdlim_nxt;
  logic [3:0] unit_r, unit_nxt;
  logic [15:0] dev_r, dev_nxt, ivl_r, ivl_nxt;
  logic [1:0] prv_r, prv_nxt;
  logic [3:0] alm_r, alm_nxt;
  logic [31:0] hrdata_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wa_r, wa_nxt;
  ptsio_pkg::ptsio_home_t hst_r, hst_nxt;
  logic done_nxt, act_nxt, inpos_nxt, fault_nxt, srv_nxt, ener_nxt;

  ////////////////////////////////////////////////////////////////////////
  // command decode and deviation counter
  logic pul, dirv, ld;
  logic cmd_up, cmd_dn, cmd_step;
  logic [15:0] dev_abs, min_cyc;
  ptsio_pkg::ptsio_form_t form;
  assign form = ptsio_pkg::ptsio_form_t'(ctrl_r[1:0]);
  assign ld = ctrl_r[`PTSIO_CTRL_LD];
  assign pul = ld ? s2_r[0] : s2_r[1];
  assign dirv = ld ? s2_r[2] : s2_r[3];
  assign min_cyc = ld ? 16'(`PTSIO_LD_MIN_CYC) : 16'(`PTSIO_OC_MIN_CYC);
  assign cmd_step = cmd_up | cmd_dn;
  assign dev_abs = dev_r[15] ? 16'(-dev_r) : dev_r;

  always_comb begin
    cmd_up = 1'b0;
    cmd_dn = 1'b0;
    case (form)
      ptsio_pkg::form_quad: begin
        if ((pul ^ prv_r[0]) ^ (dirv ^ prv_r[1])) begin
          cmd_up = ~(prv_r[0] ^ dirv);
          cmd_dn = prv_r[0] ^ dirv;
        end
      end
      ptsio_pkg::form_psign: begin
        cmd_up = pul & ~prv_r[0] & dirv;
        cmd_dn = pul & ~prv_r[0] & ~dirv;
      end
      ptsio_pkg::form_cwccw: begin
        cmd_up = pul & ~prv_r[0] & ~(dirv & ~prv_r[1]);
        cmd_dn = dirv & ~prv_r[1] & ~(pul & ~prv_r[0]);
      end
      default: begin
        cmd_up = 1'b0;
        cmd_dn = 1'b0;
      end
    endcase
    prv_nxt = {dirv, pul};
    dev_nxt = dev_r;
    if (cmd_up) dev_nxt = dev_nxt + 16'h0001;
    if (cmd_dn) dev_nxt = dev_nxt - 16'h0001;
    if (fb_step && !fb_dir) dev_nxt = dev_nxt - 16'h0001;
    if (fb_step && fb_dir) dev_nxt = dev_nxt + 16'h0001;
    if (cmd_step) ivl_nxt = 16'h0000;
    else if (ivl_r != `PTSIO_IVL_MAX) ivl_nxt = ivl_r + 16'h0001;
    else ivl_nxt = ivl_r;
    inpos_nxt = dev_abs <= tol_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prv_r <= 2'h0;
      dev_r <= 16'h0000;
      ivl_r <= `PTSIO_IVL_MAX;
      in_position <= 1'b0;
    end else begin
      prv_r <= prv_nxt;
      dev_r <= dev_nxt;
      ivl_r <= ivl_nxt;
      in_position <= inpos_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm latch; a new cause beats a clear in the same cycle
  logic [3:0] cause;
  always_comb begin
    cause = 4'h0;
    cause[`PTSIO_ALM_DEV] = dev_abs > devlim_r;
    cause[`PTSIO_ALM_SPD] = cmd_step && spdlim_r != 16'h0000 &&
                            ivl_r < spdlim_r;
    cause[`PTSIO_ALM_FRQ] = cmd_step && ivl_r < min_cyc;
    cause[`PTSIO_ALM_EXT] = ext_s;
    if (rst_s && cause == 4'h0) alm_nxt = 4'h0;
    else alm_nxt = alm_r | cause;
    fault_nxt = ~|alm_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alm_r <= 4'h0;
      fault_n <= 1'b1;
    end else begin
      alm_r <= alm_nxt;
      fault_n <= fault_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // servo and home search
  always_comb begin
    // energize follows enable; an alarm also drops it
    ener_nxt = en_s & ~|alm_r;
    // servo-on only once the stage reports ready
    srv_nxt = motor_energize & motor_ready & ener_nxt;
    hst_nxt = hst_r;
    case (hst_r)
      ptsio_pkg::home_idle: begin
        if (home_s && servo_state_out) hst_nxt = ptsio_pkg::home_search;
      end
      ptsio_pkg::home_search: begin
        // abort on release or servo loss
        if (!home_s || !servo_state_out) hst_nxt = ptsio_pkg::home_idle;
        else if (home_found) hst_nxt = ptsio_pkg::home_done;
      end
      ptsio_pkg::home_done: begin
        if (!servo_state_out) hst_nxt = ptsio_pkg::home_idle;
      end
      default: hst_nxt = ptsio_pkg::home_idle;
    endcase
    done_nxt = hst_nxt == ptsio_pkg::home_done;
    act_nxt = hst_nxt == ptsio_pkg::home_search;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hst_r <= ptsio_pkg::home_idle;
      homing_done <= 1'b0;
      homing_active <= 1'b0;
      motor_energize <= 1'b0;
      servo_state_out <= 1'b0;
    end else begin
      hst_r <= hst_nxt;
      homing_done <= done_nxt;
      homing_active <= act_nxt;
      motor_energize <= ener_nxt;
      servo_state_out <= srv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait; reads see this cycle's write
  logic take, mapped;
  logic [7:0] ra;
  assign take = hsel & htrans[1] & hready;
  assign ra = haddr[7:0];
  assign mapped = haddr[31:8] == 24'h000000;
  always_comb begin
    ctrl_nxt = ctrl_r;
    tol_nxt = tol_r;
    devlim_nxt = devlim_r;
    spdlim_nxt = spdlim_r;
    unit_nxt = unit_r;
    if (wr_pend_r) begin
      case (wa_r)
        `PTSIO_A_CTRL: ctrl_nxt = hwdata[2:0];
        `PTSIO_A_TOL: tol_nxt = hwdata[15:0];
        `PTSIO_A_DEVLIM: devlim_nxt = hwdata[15:0];
        `PTSIO_A_SPDLIM: spdlim_nxt = hwdata[15:0];
        `PTSIO_A_UNIT: unit_nxt = hwdata[3:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    wr_pend_nxt = take & hwrite & mapped;
    wa_nxt = ra;
    hrdata_nxt = 32'h00000000;
    if (take && !hwrite && mapped) begin
      case (ra)
        `PTSIO_A_CTRL: hrdata_nxt = {29'h0, ctrl_nxt};
        `PTSIO_A_TOL: hrdata_nxt = {16'h0, tol_nxt};
        `PTSIO_A_DEVLIM: hrdata_nxt = {16'h0, devlim_nxt};
        `PTSIO_A_SPDLIM: hrdata_nxt = {16'h0, spdlim_nxt};
        `PTSIO_A_DEV: hrdata_nxt = {16'h0, dev_r};
        `PTSIO_A_STAT: hrdata_nxt = {20'h0, alm_r, 3'h0, homing_active,
          in_position, homing_done, servo_state_out, fault_n};
        `PTSIO_A_UNIT: hrdata_nxt = {28'h0, unit_nxt};
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `PTSIO_RST_CTRL;
      tol_r <= `PTSIO_RST_TOL;
      devlim_r <= `PTSIO_RST_DEVLIM;
      spdlim_r <= `PTSIO_RST_SPDLIM;
      unit_r <= `PTSIO_RST_UNIT;
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      tol_r <= tol_nxt;
      devlim_r <= devlim_nxt;
      spdlim_r <= spdlim_nxt;
      unit_r <= unit_nxt;
      wr_pend_r <= wr_pend_nxt;
      wa_r <= wa_nxt;
      hrdata <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  psign_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    form == ptsio_pkg::form_psign && pul && !prv_r[0] && dirv && !fb_step
    |=> dev_r == $past(dev_r) + 16'h0001)
    else $error("pulse/sign step not counted up");
  home_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
    homing_active && !home_s |=> !homing_active ##1 !homing_done)
    else $error("home search not aborted");
  energize_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !en_s |=> !motor_energize)
    else $error("motor energized without enable");
  home_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    homing_active && home_found && home_s && servo_state_out
    |=> homing_done && !homing_active)
    else $error("homing done not raised");
  inpos_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dev_abs > tol_r |=> !in_position)
    else $error("in position outside tolerance");
  fault_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cause != 4'h0 |=> !fault_n && (alm_r & $past(cause)) == $past(cause))
    else $error("fault output not dropped");
  servo_state_a: assert property (@(posedge hclk) disable iff (!hresetn)
    servo_state_out |-> $past(motor_energize) && motor_energize)
    else $error("servo state without energized motor");
  freq_over_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_step && ivl_r < min_cyc
    |=> alm_r[`PTSIO_ALM_FRQ] ##1 !motor_energize)
    else $error("pulse frequency overrun missed");
  alarm_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rst_s && cause == 4'h0 && alm_r != 4'h0 |=> alm_r == 4'h0 && fault_n)
    else $error("alarm not cleared");

endmodule

// >>> inc/ptsio_map.svh
// register map, field positions, reset values and timing counts
// of the pulse-train servo i/o block; definitions only
`ifndef PTSIO_MAP_SVH
`define PTSIO_MAP_SVH
`define PTSIO_CLK_NS 8
`define PTSIO_LD_MIN_NS 2000
`define PTSIO_OC_MIN_NS 10000
`define PTSIO_LD_MIN_CYC ((`PTSIO_LD_MIN_NS+`PTSIO_CLK_NS-1)/`PTSIO_CLK_NS)
`define PTSIO_OC_MIN_CYC ((`PTSIO_OC_MIN_NS+`PTSIO_CLK_NS-1)/`PTSIO_CLK_NS)
`define PTSIO_A_CTRL 8'h00
`define PTSIO_A_TOL 8'h04
`define PTSIO_A_DEVLIM 8'h08
`define PTSIO_A_SPDLIM 8'h0C
`define PTSIO_A_DEV 8'h10
`define PTSIO_A_STAT 8'h14
`define PTSIO_A_UNIT 8'h18
`define PTSIO_CTRL_LD 2
`define PTSIO_RST_CTRL 3'h0
`define PTSIO_RST_TOL 16'h000A
`define PTSIO_RST_DEVLIM 16'h1000
`define PTSIO_RST_SPDLIM 16'h0000
`define PTSIO_RST_UNIT 4'h0
`define PTSIO_ALM_DEV 0
`define PTSIO_ALM_SPD 1
`define PTSIO_ALM_FRQ 2
`define PTSIO_ALM_EXT 3
`define PTSIO_ALM_LSB 8
`define PTSIO_IVL_MAX 16'hFFFF
`endif

// >>> inc/ptsio_pkg.sv
// types shared by the pulse-train servo i/o block
// assumes nothing of its surroundings
package ptsio_pkg;
  typedef enum logic [1:0] {form_quad, form_psign, form_cwccw} ptsio_form_t;
  typedef enum logic [1:0] {home_idle, home_search, home_done} ptsio_home_t;
endpackage

// >>> tb/ptsio_host.sv
// host pulse generator model driving the command pins
// assumes the caller picks a gap that suits the mode
`timescale 1ns/1ps
module ptsio_host (
  input wire logic hclk,
  output logic pulse_a,
  output logic pulse_b,
  output logic dir_a,
  output logic dir_b
);
  logic p = 1'b0;
  logic d = 1'b0;
  logic ld = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // pin pairing
  // unused first pins in open collector mode toggle opposite, never float
  assign pulse_a = ld ? p : ~p;
  assign pulse_b = ~pulse_a;
  assign dir_a = ld ? d : ~d;
  assign dir_b = ~dir_a;
  ////////////////////////////////////////////////////////////////////////
  // pin pair in use, set before the decoder switches pairs
  task automatic mode(input bit m);
    ld = m;
  endtask
  task automatic send(input int f, input int n, input int gap, input bit m);
    ld = m;
    if (f == 1) begin
      d <= 1'b1;
      repeat (gap) @(posedge hclk);
    end
    for (int i = 1; i <= n; i++) begin
      if (f == 0) begin
        p <= (i % 4 == 1) || (i % 4 == 2);
        d <= (i % 4 == 2) || (i % 4 == 3);
        repeat (gap) @(posedge hclk);
      end else begin
        p <= 1'b1;
        repeat (gap) @(posedge hclk);
        p <= 1'b0;
        repeat (gap) @(posedge hclk);
      end
    end
    d <= 1'b0;
    repeat (gap) @(posedge hclk);
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the pulse-train servo i/o block
// assumes one ahb-lite slave whose hreadyout is the bus hready
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pa, pb, da, db, home_request, motor_enable_in_alt;
  logic alarm_reset_in, ext_fault_in, home_found, motor_ready;
  logic fb_step, fb_dir, homing_done, homing_active, in_position;
  logic fault_n, servo_state_out, motor_energize;
  int failures, total_checks, cyc;
  assign hready = hreadyout;
  ptsio_top ptsio_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .cmd_pulse_in_a(pa), .cmd_pulse_in_b(pb), .cmd_direction_in_a(da),
    .cmd_direction_in_b(db), .home_request, .motor_enable_in_alt,
    .alarm_reset_in, .ext_fault_in, .home_found, .motor_ready, .fb_step,
    .fb_dir, .homing_done, .homing_active, .in_position, .fault_n,
    .servo_state_out, .motor_energize);
  ptsio_host ptsio_host_i (.hclk, .pulse_a(pa), .pulse_b(pb), .dir_a(da),
    .dir_b(db));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // read data is taken at the edge that ends the data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_q, e);
    chk1(hresp, 1'b0);
  endtask
  task clr;
    alarm_reset_in <= 1'b1;
    wt(4);
    alarm_reset_in <= 1'b0;
    wt(4);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {failures, total_checks, cyc} = '0;
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {home_request, motor_enable_in_alt, alarm_reset_in} = '0;
    {ext_fault_in, home_found, motor_ready, fb_step, fb_dir} = '0;
    wt(6);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0000000A);
    rd(8'h08, 32'h00001000);
    bus(1'b1, 8'h18, 32'h0000000F);
    rd(8'h18, 32'h0000000F);
    bus(1'b1, 8'h1C, 32'h00000055);
    rd(8'h1C, 32'h0);
    chk1(fault_n, 1'b1);
    $display("test registers done");
    motor_ready <= 1'b1;
    motor_enable_in_alt <= 1'b1;
    wt(8);
    chk1(motor_energize, 1'b1);
    chk1(servo_state_out, 1'b1);
    rd(8'h14, 32'h0000000B);
    $display("test servo done");
    for (int f = 0; f < 3; f++) begin
      bus(1'b1, 8'h00, 32'h00000004 | 32'(f));
      ptsio_host_i.send(f, 4, 300, 1'b1);
      wt(8);
      rd(8'h10, 32'(4 * (f + 1)));
      chk1(in_position, f < 2);
    end
    // park the host on the second pins before the decoder moves to them
    ptsio_host_i.mode(1'b0);
    bus(1'b1, 8'h00, 32'h00000001);
    ptsio_host_i.send(1, 2, 1300, 1'b0);
    wt(8);
    rd(8'h10, 32'h0000000E);
    // feedback counts pull the deviation back to zero
    fb_step <= 1'b1;
    wt(14);
    fb_step <= 1'b0;
    wt(2);
    rd(8'h10, 32'h0);
    chk1(in_position, 1'b1);
    // form code 3 counts nothing
    bus(1'b1, 8'h00, 32'h00000003);
    ptsio_host_i.send(1, 2, 300, 1'b0);
    wt(8);
    rd(8'h10, 32'h0);
    bus(1'b1, 8'h00, 32'h00000001);
    $display("test pulses done");
    // too dense for open collector: frequency alarm
    ptsio_host_i.send(1, 2, 20, 1'b0);
    chk1(fault_n, 1'b0);
    chk1(motor_energize, 1'b0);
    clr;
    chk1(fault_n, 1'b1);
    ext_fault_in <= 1'b1;
    wt(6);
    chk1(fault_n, 1'b0);
    clr;
    chk1(fault_n, 1'b0);
    ext_fault_in <= 1'b0;
    clr;
    chk1(fault_n, 1'b1);
    wt(8);
    chk1(servo_state_out, 1'b1);
    $display("test alarms done");
    home_request <= 1'b1;
    wt(8);
    chk1(homing_active, 1'b1);
    home_request <= 1'b0;
    wt(8);
    chk1(homing_active, 1'b0);
    chk1(homing_done, 1'b0);
    home_request <= 1'b1;
    wt(8);
    home_found <= 1'b1;
    wt(1);
    home_found <= 1'b0;
    wt(4);
    chk1(homing_done, 1'b1);
    chk1(homing_active, 1'b0);
    $display("test homing done");
    close_out;
  end
endmodule
